// File: telegram_pkg.sv
package telegram_pkg;

	// Scanner side records
	typedef struct packed {
		logic        valid;
		logic [15:0] angle;
		logic [15:0] distance;
		logic        in_prot;
		logic        in_warn;
	} beam_t;

	typedef struct packed {
		logic        hit;
		logic [15:0] angle;
		logic [15:0] distance;
	} violation_t;

	// Telegram images, index is byte in module
	typedef logic [6:0][7:0]  safe_in_t;
	typedef logic [10:0][7:0] safe_out_t;
	typedef logic [7:0][7:0]  violation_msg_t;

	typedef enum logic [1:0] {
		FM_PAIRS_5_10 = 2'b00,
		FM_PAIRS_100  = 2'b01,
		FM_MULTI_CFG  = 2'b10,
		FM_TWO_FUNC   = 2'b11
	} func_mode_t;

	// Non-safe telegram numbering of the function B violation module
	localparam int unsigned VIO_TELEGRAM_BASE = 20;
	localparam int unsigned VIO_PROT_ANGLE    = 0;
	localparam int unsigned VIO_PROT_DIST     = 2;
	localparam int unsigned VIO_WARN_ANGLE    = 4;
	localparam int unsigned VIO_WARN_DIST     = 6;

	// Safe input frame
	localparam int unsigned SIN_FNA       = 0;
	localparam int unsigned SIN_FNB       = 1;
	localparam int unsigned SIN_RSVD      = 2;
	localparam int unsigned SIN_STATUS    = 3;
	localparam int unsigned SIN_CRC_HIGH  = 4;
	localparam int unsigned SIN_CRC_MID   = 5;
	localparam int unsigned SIN_CRC_LOW   = 6;
	localparam int unsigned BIT_WARN_FREE = 0;
	localparam int unsigned BIT_PROT_FREE = 1;

	// Safe output frame, 5/10 field pair layout
	localparam int unsigned SOUT_SWITCH    = 0;
	localparam int unsigned SOUT_START     = 4;
	localparam int unsigned BIT_START_WARN = 0;
	localparam int unsigned BIT_START_PROT = 1;
	localparam int unsigned SWITCH_BITS    = 5;

	// APB map
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h08;
	localparam logic [7:0] ADDR_PROT_REC  = 8'h0c;
	localparam logic [7:0] ADDR_WARN_REC  = 8'h10;
	localparam logic [7:0] ADDR_CMD_STAT  = 8'h14;

	localparam logic [1:0] CTRL_RESET     = 2'h0;
	localparam int unsigned IRQ_BITS      = 4;
	localparam int unsigned IRQ_SCAN_DONE = 0;
	localparam int unsigned IRQ_PROT_VIO  = 1;
	localparam int unsigned IRQ_FRAME_RX  = 2;
	localparam int unsigned IRQ_START_REQ = 3;

endpackage

// File: first_violation.sv
`timescale 1ns/1ps

// Holds the first beam of a scan that lies in one field
module first_violation (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     scan_start,
	input  wire logic                     scan_end,
	input  wire telegram_pkg::beam_t      beam,
	input  wire logic                     beam_in_field,
	output      telegram_pkg::violation_t record
);

	telegram_pkg::violation_t scan_q;
	telegram_pkg::violation_t scan_d;
	telegram_pkg::violation_t rec_q;
	telegram_pkg::violation_t rec_d;

	always_comb begin
		scan_d = scan_q;
		rec_d  = rec_q;
		if (scan_start) begin
			scan_d = '0;
		end
		// Beams arrive in rotation order, so the first hit wins
		if (beam.valid && beam_in_field && !scan_q.hit) begin
			scan_d.hit      = 1'b1;
			scan_d.angle    = beam.angle;
			scan_d.distance = beam.distance;
		end
		if (scan_end) begin
			rec_d = scan_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q <= '0;
			rec_q  <= '0;
		end else begin
			scan_q <= scan_d;
			rec_q  <= rec_d;
		end
	end

	assign record = rec_q;

endmodule

// File: telegram_mapper.sv
`timescale 1ns/1ps

// What this block does
// - Report first violated beam per scan, protective and warning fields kept apart.
// - Protective violation angle, signed 16 bit, at non-safe byte 20.
// - Protective violation distance, unsigned 16 bit, at non-safe byte 22.
// - Warning violation angle at byte 24, distance at byte 26.
// - Safe byte 0: bit 0 warning free, bit 1 protective free, function A.
// - Safe byte 1: same flags for function B, bits 2 to 7 reserved.
// - Byte 2 reserved, byte 3 profile status, bytes 4 to 6 CRC high to low.
// - Safe switching signals travel only in the safe output frame.
// - Output bytes 0 to 4 decoded only in the 5/10 field pair mode; other modes are not decoded and set mode_unsupported.
// - Received commands select protective field switchover.
// - Manual start or restart released only by a received start signal.
module telegram_mapper (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output      logic [31:0]                  prdata,
	output      logic                         pready,
	output      logic                         pslverr,
	output      logic                         irq,
	input  wire logic                         scan_start,
	input  wire logic                         scan_end,
	input  wire telegram_pkg::beam_t          beam,
	input  wire logic                         fna_warn_free,
	input  wire logic                         fna_prot_free,
	input  wire logic [7:0]                   tx_profile_status,
	input  wire logic [23:0]                  tx_crc,
	output      telegram_pkg::safe_in_t       safe_io_frame,
	output      telegram_pkg::violation_msg_t violation_msg,
	input  wire telegram_pkg::safe_out_t      rx_frame,
	input  wire logic                         rx_valid,
	output      logic [4:0]                   field_switchover,
	output      logic                         start_warn_release,
	output      logic                         start_prot_release,
	output      logic                         mode_unsupported
);

	telegram_pkg::violation_t prot_rec;
	telegram_pkg::violation_t warn_rec;

	first_violation u_prot (
		.pclk          (pclk),
		.presetn       (presetn),
		.scan_start    (scan_start),
		.scan_end      (scan_end),
		.beam          (beam),
		.beam_in_field (beam.in_prot),
		.record        (prot_rec)
	);

	first_violation u_warn (
		.pclk          (pclk),
		.presetn       (presetn),
		.scan_start    (scan_start),
		.scan_end      (scan_end),
		.beam          (beam),
		.beam_in_field (beam.in_warn),
		.record        (warn_rec)
	);

	// Telegram images
	telegram_pkg::safe_in_t       sin_q;
	telegram_pkg::safe_in_t       sin_d;
	telegram_pkg::violation_msg_t vmsg_q;
	telegram_pkg::violation_msg_t vmsg_d;

	always_comb begin
		sin_d  = '0;
		vmsg_d = '0;
		sin_d[telegram_pkg::SIN_FNA][telegram_pkg::BIT_WARN_FREE] = fna_warn_free;
		sin_d[telegram_pkg::SIN_FNA][telegram_pkg::BIT_PROT_FREE] = fna_prot_free;
		// Function B free means no beam of the last scan was in the field
		sin_d[telegram_pkg::SIN_FNB][telegram_pkg::BIT_WARN_FREE] = !warn_rec.hit;
		sin_d[telegram_pkg::SIN_FNB][telegram_pkg::BIT_PROT_FREE] = !prot_rec.hit;
		sin_d[telegram_pkg::SIN_RSVD]     = 8'h00;
		sin_d[telegram_pkg::SIN_STATUS]   = tx_profile_status;
		sin_d[telegram_pkg::SIN_CRC_HIGH] = tx_crc[23:16];
		sin_d[telegram_pkg::SIN_CRC_MID]  = tx_crc[15:8];
		sin_d[telegram_pkg::SIN_CRC_LOW]  = tx_crc[7:0];
		// Most significant byte first; no clear flags here
		vmsg_d[telegram_pkg::VIO_PROT_ANGLE]     = prot_rec.angle[15:8];
		vmsg_d[telegram_pkg::VIO_PROT_ANGLE + 1] = prot_rec.angle[7:0];
		vmsg_d[telegram_pkg::VIO_PROT_DIST]      = prot_rec.distance[15:8];
		vmsg_d[telegram_pkg::VIO_PROT_DIST + 1]  = prot_rec.distance[7:0];
		vmsg_d[telegram_pkg::VIO_WARN_ANGLE]     = warn_rec.angle[15:8];
		vmsg_d[telegram_pkg::VIO_WARN_ANGLE + 1] = warn_rec.angle[7:0];
		vmsg_d[telegram_pkg::VIO_WARN_DIST]      = warn_rec.distance[15:8];
		vmsg_d[telegram_pkg::VIO_WARN_DIST + 1]  = warn_rec.distance[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sin_q  <= '0;
			vmsg_q <= '0;
		end else begin
			sin_q  <= sin_d;
			vmsg_q <= vmsg_d;
		end
	end

	assign safe_io_frame = sin_q;
	assign violation_msg = vmsg_q;

	// Command decode
	telegram_pkg::func_mode_t mode_q;
	telegram_pkg::func_mode_t mode_d;
	logic [4:0]               switch_q;
	logic [4:0]               switch_d;
	logic                     warn_lvl_q;
	logic                     warn_lvl_d;
	logic                     prot_lvl_q;
	logic                     prot_lvl_d;
	logic                     warn_rel_q;
	logic                     warn_rel_d;
	logic                     prot_rel_q;
	logic                     prot_rel_d;
	logic                     rx_warn;
	logic                     rx_prot;

	assign rx_warn = rx_frame[telegram_pkg::SOUT_START][telegram_pkg::BIT_START_WARN];
	assign rx_prot = rx_frame[telegram_pkg::SOUT_START][telegram_pkg::BIT_START_PROT];

	always_comb begin
		switch_d   = switch_q;
		warn_lvl_d = warn_lvl_q;
		prot_lvl_d = prot_lvl_q;
		warn_rel_d = 1'b0;
		prot_rel_d = 1'b0;
		// Other layouts are not decoded; last valid selection is kept
		if (rx_valid && mode_q == telegram_pkg::FM_PAIRS_5_10) begin
			// Reserved bits 5 to 7 and bytes 1 to 3 are masked out
			switch_d   = rx_frame[telegram_pkg::SOUT_SWITCH][telegram_pkg::SWITCH_BITS-1:0];
			warn_lvl_d = rx_warn;
			prot_lvl_d = rx_prot;
			// Release on the rising edge only, so a stuck bit cannot restart twice
			warn_rel_d = rx_warn && !warn_lvl_q;
			prot_rel_d = rx_prot && !prot_lvl_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_q   <= '0;
			warn_lvl_q <= 1'b0;
			prot_lvl_q <= 1'b0;
			warn_rel_q <= 1'b0;
			prot_rel_q <= 1'b0;
		end else begin
			switch_q   <= switch_d;
			warn_lvl_q <= warn_lvl_d;
			prot_lvl_q <= prot_lvl_d;
			warn_rel_q <= warn_rel_d;
			prot_rel_q <= prot_rel_d;
		end
	end

	assign field_switchover   = switch_q;
	assign start_warn_release = warn_rel_q;
	assign start_prot_release = prot_rel_q;
	assign mode_unsupported   = (mode_q != telegram_pkg::FM_PAIRS_5_10);

	// Register map, byte addresses on the APB side
	//   CTRL      mode select in the low bits
	//   IRQ_STAT  sticky events, cleared by reading
	//   IRQ_MASK  same layout as IRQ_STAT
	//   PROT_REC  protective record, angle in the high half
	//   WARN_REC  warning record, angle in the high half
	//   CMD_STAT  decoded command levels, read only
	// Read data is latched in setup, so access never needs a wait
	// APB slave, zero wait states
	logic                          setup;
	logic                          access;
	logic                          wr_en;
	logic                          rd_en;
	logic                          mapped;
	logic [31:0]                   rdata_q;
	logic [31:0]                   rdata_d;
	logic                          err_q;
	logic                          err_d;
	logic [telegram_pkg::IRQ_BITS-1:0] stat_q;
	logic [telegram_pkg::IRQ_BITS-1:0] stat_d;
	logic [telegram_pkg::IRQ_BITS-1:0] mask_q;
	logic [telegram_pkg::IRQ_BITS-1:0] mask_d;
	logic [telegram_pkg::IRQ_BITS-1:0] events;
	logic                          scan_done_q;
	logic                          scan_done_d;

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wr_en  = access && pwrite;
	assign rd_en  = access && !pwrite;

	always_comb begin
		unique case (paddr)
			telegram_pkg::ADDR_CTRL,
			telegram_pkg::ADDR_IRQ_STAT,
			telegram_pkg::ADDR_IRQ_MASK,
			telegram_pkg::ADDR_PROT_REC,
			telegram_pkg::ADDR_WARN_REC,
			telegram_pkg::ADDR_CMD_STAT: mapped = 1'b1;
			default:                     mapped = 1'b0;
		endcase
	end

	always_comb begin
		events                              = '0;
		events[telegram_pkg::IRQ_SCAN_DONE] = scan_done_q;
		events[telegram_pkg::IRQ_PROT_VIO]  = scan_done_q && prot_rec.hit;
		events[telegram_pkg::IRQ_FRAME_RX]  = rx_valid;
		events[telegram_pkg::IRQ_START_REQ] = warn_rel_q || prot_rel_q;
	end

	always_comb begin
		mode_d  = mode_q;
		mask_d  = mask_q;
		stat_d  = stat_q;
		rdata_d = rdata_q;
		err_d   = 1'b0;
		// Delayed so the records have settled before the event fires
		scan_done_d = scan_end;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			err_d   = !mapped;
			unique case (paddr)
				telegram_pkg::ADDR_CTRL:     rdata_d[1:0] = mode_q;
				telegram_pkg::ADDR_IRQ_STAT: rdata_d[telegram_pkg::IRQ_BITS-1:0] = stat_q;
				telegram_pkg::ADDR_IRQ_MASK: rdata_d[telegram_pkg::IRQ_BITS-1:0] = mask_q;
				telegram_pkg::ADDR_PROT_REC: rdata_d = {prot_rec.angle, prot_rec.distance};
				telegram_pkg::ADDR_WARN_REC: rdata_d = {warn_rec.angle, warn_rec.distance};
				telegram_pkg::ADDR_CMD_STAT:
					rdata_d[7:0] = {mode_unsupported, prot_lvl_q, warn_lvl_q, switch_q};
				default:                     rdata_d = 32'h0000_0000;
			endcase
		end
		if (wr_en && paddr == telegram_pkg::ADDR_CTRL) begin
			mode_d = telegram_pkg::func_mode_t'(pwdata[1:0]);
		end
		if (wr_en && paddr == telegram_pkg::ADDR_IRQ_MASK) begin
			mask_d = pwdata[telegram_pkg::IRQ_BITS-1:0];
		end
		if (rd_en && paddr == telegram_pkg::ADDR_IRQ_STAT) begin
			stat_d = '0;
		end
		// New events beat the read clear
		stat_d = stat_d | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q      <= telegram_pkg::func_mode_t'(telegram_pkg::CTRL_RESET);
			mask_q      <= '0;
			stat_q      <= '0;
			rdata_q     <= '0;
			err_q       <= 1'b0;
			scan_done_q <= 1'b0;
		end else begin
			mode_q      <= mode_d;
			mask_q      <= mask_d;
			stat_q      <= stat_d;
			rdata_q     <= rdata_d;
			err_q       <= err_d;
			scan_done_q <= scan_done_d;
		end
	end

	assign prdata  = rdata_q;
	assign pready  = 1'b1;
	// Error flag latched in setup, so it stands for the whole access
	assign pslverr = err_q && access;
	assign irq     = |(stat_q & mask_q);

endmodule

// File: telegram_mapper_monitor.sv
`timescale 1ns/1ps
module telegram_mapper_monitor (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         scan_end,
	input wire logic                         fna_warn_free,
	input wire logic                         fna_prot_free,
	input wire logic [7:0]                   tx_profile_status,
	input wire logic [23:0]                  tx_crc,
	input wire telegram_pkg::safe_in_t       safe_io_frame,
	input wire telegram_pkg::violation_msg_t violation_msg,
	input wire telegram_pkg::safe_out_t      rx_frame,
	input wire logic                         rx_valid,
	input wire logic [4:0]                   field_switchover,
	input wire logic                         start_warn_release,
	input wire logic                         start_prot_release,
	input wire logic                         mode_unsupported
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Records may only move two edges after a scan closes
	sequence quiet_s;
		presetn && !scan_end ##1 !scan_end;
	endsequence
	AST_FNA_FLAGS: assert property ($past(presetn) |->
		safe_io_frame[0] == {6'h00, $past(fna_prot_free), $past(fna_warn_free)})
		else $error("function A flags wrong");
	AST_TRAILER: assert property ($past(presetn) |-> safe_io_frame[3] == $past(tx_profile_status)
		&& {safe_io_frame[4], safe_io_frame[5], safe_io_frame[6]} == $past(tx_crc))
		else $error("safe trailer wrong");
	AST_RESERVED: assert property (safe_io_frame[1][7:2] == 6'h00 && safe_io_frame[2] == 8'h00)
		else $error("reserved safe bits set");
	AST_VIO_HOLD: assert property (quiet_s |=> $stable(violation_msg))
		else $error("violation record moved without scan end");
	AST_FNB_HOLD: assert property (quiet_s |=> $stable(safe_io_frame[1]))
		else $error("function B flags moved without scan end");
	AST_SWITCH: assert property (rx_valid && !mode_unsupported |=>
		field_switchover == $past(rx_frame[0][4:0]))
		else $error("switchover not taken");
	AST_SWITCH_HOLD: assert property (!(rx_valid && !mode_unsupported) |=> $stable(field_switchover))
		else $error("switchover moved without frame");
	AST_START_WARN: assert property (start_warn_release |-> $past(rx_valid) && $past(rx_frame[4][0]))
		else $error("warn release without start bit");
	AST_START_PROT: assert property (start_prot_release |->
		($past(rx_valid) && $past(rx_frame[4][1])) ##1 !start_prot_release)
		else $error("prot release bad");
endmodule

bind telegram_mapper telegram_mapper_monitor i_telegram_mapper_monitor (.pclk, .presetn, .scan_end,
	.fna_warn_free, .fna_prot_free, .tx_profile_status, .tx_crc, .safe_io_frame, .violation_msg,
	.rx_frame, .rx_valid, .field_switchover, .start_warn_release, .start_prot_release,
	.mode_unsupported);

// File: plc_model.sv
`timescale 1ns/1ps
module plc_model (
	input  wire logic                    pclk,
	output      telegram_pkg::safe_out_t rx_frame,
	output      logic                    rx_valid
);
	initial begin
		rx_frame = '0;
		rx_valid = 1'h0;
	end
	// Between frames the bytes are inverted so a stale capture shows
	task automatic send(input logic [4:0] sel, input logic [1:0] start, input logic dirty);
		telegram_pkg::safe_out_t f;
		f = {11{dirty ? 8'hff : 8'h00}};
		f[0][4:0] = sel;
		f[4][1:0] = start;
		f[7] = 8'h3c;
		f[10:8] = 24'h9e5a17;
		@(posedge pclk);
		rx_frame <= f;
		rx_valid <= 1'h1;
		@(posedge pclk);
		rx_frame <= ~f;
		rx_valid <= 1'h0;
	endtask
endmodule

// File: test_safety_scanner_telegram_mapper.sv
`timescale 1ns/1ps
module test_safety_scanner_telegram_mapper;
	logic                         pclk = 1'h0;
	logic                         presetn = 1'h0;
	logic                         psel = 1'h0;
	logic                         penable = 1'h0;
	logic                         pwrite = 1'h0;
	logic [7:0]                   paddr = 8'h00;
	logic [31:0]                  pwdata = 32'h0;
	logic [31:0]                  prdata;
	logic                         pready;
	logic                         pslverr;
	logic                         irq;
	logic                         scan_start = 1'h0;
	logic                         scan_end = 1'h0;
	telegram_pkg::beam_t          beam = '0;
	logic                         fna_warn_free = 1'h0;
	logic                         fna_prot_free = 1'h0;
	logic [7:0]                   tx_profile_status = 8'h00;
	logic [23:0]                  tx_crc = 24'h0;
	telegram_pkg::safe_in_t       safe_io_frame;
	telegram_pkg::violation_msg_t violation_msg;
	telegram_pkg::safe_out_t      rx_frame;
	logic                         rx_valid;
	logic [4:0]                   field_switchover;
	logic                         start_warn_release;
	logic                         start_prot_release;
	logic                         mode_unsupported;
	logic [31:0]                  rd;
	logic                         err;
	int                           n_fail = 0;
	int                           tests_run = 0;

	telegram_mapper i_telegram_mapper (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .scan_start, .scan_end, .beam, .fna_warn_free,
		.fna_prot_free, .tx_profile_status, .tx_crc, .safe_io_frame, .violation_msg, .rx_frame,
		.rx_valid, .field_switchover, .start_warn_release, .start_prot_release, .mode_unsupported);
	plc_model i_plc_model (.pclk, .rx_frame, .rx_valid);

	initial begin
		forever #5 pclk = ~pclk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Idle edge first, so a release and the next setup never share a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Answer taken as it stands at the falling edge before the edge that ends the access
		do begin
			@(negedge pclk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
			@(posedge pclk);
			n++;
		end while (rdy !== 1'h1 && n < 20);
		if (rdy !== 1'h1) begin
			n_fail++;
			$display("FAIL %0t: no ready", $time);
			report_and_stop();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Free beam, warn-only beam, then the first protective beam, then a late one
	task automatic scan(input logic hit);
		scan_start <= 1'h1;
		@(posedge pclk);
		scan_start <= 1'h0;
		beam <= {1'h1, 16'h0010, 16'h0100, 1'h0, 1'h0};
		@(posedge pclk);
		beam <= {1'h1, 16'hff79, 16'h4e20, 1'h0, hit};
		@(posedge pclk);
		beam <= {1'h1, 16'h0087, 16'h203a, hit, hit};
		@(posedge pclk);
		beam <= {1'h1, 16'h0001, 16'h0002, hit, hit};
		@(posedge pclk);
		beam <= '0;
		scan_end <= 1'h1;
		@(posedge pclk);
		scan_end <= 1'h0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic frame(input logic [4:0] sel, input logic [1:0] st, input logic dirty,
		input logic [4:0] esw, input logic [1:0] ep);
		i_plc_model.send(sel, st, dirty);
		@(negedge pclk);
		chk(field_switchover, esw);
		chk({start_prot_release, start_warn_release}, ep);
	endtask

	// High byte first per field
	function automatic logic [31:0] be(input logic [15:0] a, input logic [15:0] d);
		return {d[7:0], d[15:8], a[7:0], a[15:8]};
	endfunction

	initial begin
		int i;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		tx_profile_status <= 8'ha5;
		tx_crc <= 24'h123456;
		for (i = 0; i < 4; i++) begin
			fna_warn_free <= i[0];
			fna_prot_free <= i[1];
			repeat (2) @(posedge pclk);
			chk(safe_io_frame, {8'h56, 8'h34, 8'h12, 8'ha5, 8'h00, 8'h03, 6'h00, i[1], i[0]});
		end
		$display("safe frame test done");
		apb(1'h1, telegram_pkg::ADDR_IRQ_MASK, 32'h2);
		scan(1'h1);
		chk(violation_msg, {be(16'hff79, 16'h4e20), be(16'h0087, 16'h203a)});
		chk(safe_io_frame[1], 8'h00);
		chk(irq, 1'h1);
		apb(1'h0, telegram_pkg::ADDR_PROT_REC, 32'h0);
		chk(rd, {16'h0087, 16'h203a});
		apb(1'h0, telegram_pkg::ADDR_WARN_REC, 32'h0);
		chk(rd, {16'hff79, 16'h4e20});
		apb(1'h0, telegram_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		@(posedge pclk);
		chk(irq, 1'h0);
		scan(1'h0);
		chk(violation_msg, 64'h0);
		chk(safe_io_frame[1], 8'h03);
		chk(irq, 1'h0);
		$display("scan test done");
		frame(5'h15, 2'h1, 1'h0, 5'h15, 2'h1);
		frame(5'h0a, 2'h3, 1'h0, 5'h0a, 2'h2);
		frame(5'h03, 2'h0, 1'h1, 5'h03, 2'h0);
		frame(5'h00, 2'h3, 1'h0, 5'h00, 2'h3);
		apb(1'h0, telegram_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'hd);
		for (i = 1; i < 4; i++) begin
			apb(1'h1, telegram_pkg::ADDR_CTRL, i);
			apb(1'h0, telegram_pkg::ADDR_CTRL, 32'h0);
			chk(rd, i);
			frame(5'h1f, 2'h0, 1'h0, 5'h00, 2'h0);
			chk(mode_unsupported, 1'h1);
		end
		apb(1'h1, telegram_pkg::ADDR_CTRL, 32'h0);
		@(posedge pclk);
		chk(mode_unsupported, 1'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk({err, rd}, {1'h1, 32'h0});
		$display("frame and register test done");
		report_and_stop();
	end
endmodule
